// *** inc/cc_params.svh ***
// Offsets, field positions and reset values of the capture/compare module
`ifndef CC_PARAMS_SVH
`define CC_PARAMS_SVH

// Register byte offsets
`define OFS_MODE          8'h00
`define OFS_CMP_LOW       8'h04
`define OFS_CMP_HIGH      8'h08
`define OFS_CONTROL       8'h0C
`define OFS_COUNT         8'h10
`define OFS_COUNTER_MODE  8'h14
`define OFS_FUNCTION      8'h18

// Mode register field positions
`define BIT_INT_EN        0
`define BIT_PWM           1
`define BIT_TOGGLE        2
`define BIT_MATCH         3
`define BIT_FALL          4
`define BIT_RISE          5
`define BIT_CMP_EN        6

// Control and counter mode field positions
`define BIT_EVENT_FLAG    0
`define BIT_RUN           6
`define BIT_WDT_EN        6

// Reset values
`define RST_MODE          7'h00
`define RST_CAPTURE       8'h00
`define RST_COUNT         16'h0000
`define RST_PIN           1'b0

// Bus responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// *** inc/cc_pkg.sv ***
// Types shared by the capture/compare module files
package cc_pkg;

  typedef logic [15:0] count_type;

  typedef enum logic [2:0] {
    FN_NONE,
    FN_CAPTURE,
    FN_TIMER,
    FN_HIGH_SPEED,
    FN_PWM,
    FN_WATCHDOG
  } function_type;

endpackage

// *** inc/pin_edge_if.sv ***
// Edge events of the synchronised module pin
`timescale 1ns/1ps
`default_nettype none
interface pin_edge_if;
  logic rise;
  logic fall;
  logic level;
  modport source (output rise, output fall, output level);
  modport sink   (input rise, input fall, input level);
endinterface
`default_nettype wire

// *** hdl/pin_edge_detect.sv ***
// Two-stage pin synchroniser and edge detector
`timescale 1ns/1ps
`default_nettype none
module pin_edge_detect (
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      reset_n,
  // Raw pin level
  input  wire logic      pin_in,
  // Edge events
  pin_edge_if.source     ev
);
  logic       sync_first;
  logic       sync_second;
  logic       prev;
  logic [2:0] settled;

  // Settle counter hides the reset value so no false edge is seen
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_first  <= 1'b0;
      sync_second <= 1'b0;
      prev        <= 1'b0;
      settled     <= 3'h0;
    end else begin
      sync_first  <= pin_in;
      sync_second <= sync_first;
      prev        <= sync_second;
      settled     <= {settled[1:0], 1'b1};
    end
  end

  // Edge decode from the second stage only
  assign ev.rise  = settled[2] & sync_second & ~prev;
  assign ev.fall  = settled[2] & ~sync_second & prev;
  assign ev.level = sync_second;
endmodule
`default_nettype wire

// *** hdl/capture_compare_module.sv ***
// Capture/compare module with shared count base behind AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
`include "cc_params.svh"
module capture_compare_module
  import cc_pkg::*;
#(
  parameter int MODULE_INDEX = 4,
  parameter int ADDR_WIDTH   = 8
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Module pin
  input  wire logic                  module_pin_in,
  output logic                       module_pin_out,
  output logic                       module_pin_oe,
  // Events to the system
  output logic                       interrupt_request,
  output logic                       watchdog_reset
);
  localparam bit IS_WATCHDOG = (MODULE_INDEX == 4);

  pin_edge_if ev ();

  pin_edge_detect u_pin_edge (
    .clk     (clk),
    .reset_n (reset_n),
    .pin_in  (module_pin_in),
    .ev      (ev)
  );

  // Bus side state
  logic                  aw_held;
  logic [ADDR_WIDTH-1:0] aw_addr;
  logic                  w_held;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;
  // Block state
  logic [6:0]            mode;
  logic [7:0]            capture_low;
  logic [7:0]            capture_high;
  count_type             count;
  logic                  count_fresh;
  logic                  run;
  logic                  wdt_en;
  logic                  armed;
  logic                  event_flag;
  logic                  pin_level;

  // Write decode: both address and data must be held
  logic do_write;
  logic wr_hit;
  logic wr_mode;
  logic wr_low;
  logic wr_high;
  logic wr_control;
  logic wr_count_lo;
  logic wr_count_hi;
  logic wr_counter_mode_register;
  assign do_write    = aw_held & w_held & ~s_axi_bvalid;
  assign wr_mode     = do_write & (aw_addr == `OFS_MODE) & w_strb[0];
  assign wr_low      = do_write & (aw_addr == `OFS_CMP_LOW) & w_strb[0];
  assign wr_high     = do_write & (aw_addr == `OFS_CMP_HIGH) & w_strb[0];
  assign wr_control  = do_write & (aw_addr == `OFS_CONTROL) & w_strb[0];
  assign wr_count_lo = do_write & (aw_addr == `OFS_COUNT) & w_strb[0];
  assign wr_count_hi = do_write & (aw_addr == `OFS_COUNT) & w_strb[1];
  assign wr_counter_mode_register     = do_write & (aw_addr == `OFS_COUNTER_MODE) & w_strb[0];
  assign wr_hit      = (aw_addr == `OFS_MODE) | (aw_addr == `OFS_CMP_LOW)
                     | (aw_addr == `OFS_CMP_HIGH) | (aw_addr == `OFS_CONTROL)
                     | (aw_addr == `OFS_COUNT) | (aw_addr == `OFS_COUNTER_MODE);

  // Mode fields
  logic cmp_en;
  logic rise_en;
  logic fall_en;
  logic match_en;
  logic tog_en;
  logic pwm_en;
  logic int_en;
  assign int_en   = mode[`BIT_INT_EN];
  assign pwm_en   = mode[`BIT_PWM];
  assign tog_en   = mode[`BIT_TOGGLE];
  assign match_en = mode[`BIT_MATCH];
  assign fall_en  = mode[`BIT_FALL];
  assign rise_en  = mode[`BIT_RISE];
  assign cmp_en   = mode[`BIT_CMP_EN];

  // Function decode and event detection
  logic         pwm_mode;
  logic         match_hit;
  logic         capture_hit;
  logic         flag_clear;
  logic         pwm_reload;
  logic         pwm_level;
  function_type func;
  assign pwm_mode    = cmp_en & pwm_en & ~match_en & ~tog_en;
  assign match_hit   = cmp_en & match_en & armed & count_fresh
                     & (count == {capture_high, capture_low});
  assign capture_hit = (rise_en & ev.rise) | (fall_en & ev.fall);
  assign flag_clear  = wr_control & ~w_data[`BIT_EVENT_FLAG];
  assign pwm_reload  = pwm_mode & run & (count[7:0] == 8'hFF);
  assign pwm_level   = (count[7:0] >= capture_low);
  assign func = pwm_mode ? FN_PWM
              : (cmp_en & match_en & IS_WATCHDOG & wdt_en) ? FN_WATCHDOG
              : (cmp_en & match_en & tog_en) ? FN_HIGH_SPEED
              : (cmp_en & match_en) ? FN_TIMER
              : (rise_en | fall_en) ? FN_CAPTURE : FN_NONE;

  // Write channel capture; either channel may arrive first
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held      <= 1'b0;
      aw_addr      <= '0;
      w_held       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read mux; the reserved mode bit reads as zero
  logic [31:0] rd_word;
  logic        rd_hit;
  assign rd_hit = (s_axi_araddr == `OFS_MODE) | (s_axi_araddr == `OFS_CMP_LOW)
                | (s_axi_araddr == `OFS_CMP_HIGH) | (s_axi_araddr == `OFS_CONTROL)
                | (s_axi_araddr == `OFS_COUNT) | (s_axi_araddr == `OFS_COUNTER_MODE)
                | (s_axi_araddr == `OFS_FUNCTION);
  assign rd_word =
      (s_axi_araddr == `OFS_MODE)    ? {25'h0, mode} :
      (s_axi_araddr == `OFS_CMP_LOW)  ? {24'h0, capture_low} :
      (s_axi_araddr == `OFS_CMP_HIGH) ? {24'h0, capture_high} :
      (s_axi_araddr == `OFS_CONTROL)  ? {25'h0, run, 5'h00, event_flag} :
      (s_axi_araddr == `OFS_COUNT)    ? {16'h0, count} :
      (s_axi_araddr == `OFS_COUNTER_MODE) ? {25'h0, wdt_en, 6'h00} :
      (s_axi_araddr == `OFS_FUNCTION) ? {29'h0, func} : 32'h0000_0000;

  // Read channel: one read under way, answered the next cycle
  assign s_axi_arready = ~s_axi_rvalid;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode   <= `RST_MODE;
      run    <= 1'b0;
      wdt_en <= 1'b0;
    end else begin
      if (wr_mode)    mode   <= w_data[6:0];
      if (wr_control) run    <= w_data[`BIT_RUN];
      if (wr_counter_mode_register)    wdt_en <= w_data[`BIT_WDT_EN];
    end
  end

  // Free-running count base; fresh marks a new value to compare
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count       <= `RST_COUNT;
      count_fresh <= 1'b0;
    end else begin
      if (wr_count_lo | wr_count_hi) begin
        if (wr_count_lo) count[7:0]  <= w_data[7:0];
        if (wr_count_hi) count[15:8] <= w_data[15:8];
      end else if (run) begin
        count <= count + 16'h0001;  // Wraps, so an unchanged compare hits again
      end
      count_fresh <= run | wr_count_lo | wr_count_hi;
    end
  end

  // Capture/compare registers; capture wins over a software write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      capture_low  <= `RST_CAPTURE;
      capture_high <= `RST_CAPTURE;
    end else if (capture_hit) begin
      {capture_high, capture_low} <= count;
    end else begin
      if (wr_low) capture_low <= w_data[7:0];
      else if (pwm_reload) capture_low <= capture_high;
      if (wr_high) capture_high <= w_data[7:0];
    end
  end

  // Comparator suspend while a new compare value goes in
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      armed <= 1'b1;
    end else if (wr_high) begin
      armed <= 1'b1;
    end else if (wr_low) begin
      armed <= 1'b0;
    end
  end

  // Event flag: a set in the clearing cycle still wins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      event_flag <= 1'b0;
    end else begin
      event_flag <= (event_flag & ~flag_clear) | match_hit | capture_hit;
    end
  end

  // Pin driver: toggles in hardware, no software latency involved
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_level <= `RST_PIN;
    end else if (pwm_mode) begin
      pin_level <= pwm_level;
    end else if (match_hit & tog_en) begin
      pin_level <= ~pin_level;
    end
  end

  // Watchdog reset pulse, only on the watchdog-capable copy
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      watchdog_reset <= 1'b0;
    end else begin
      watchdog_reset <= IS_WATCHDOG & wdt_en & match_hit;
    end
  end

  // Pin is driven whenever the toggle bit is set or the PWM function owns it
  assign module_pin_out    = pin_level;
  assign module_pin_oe     = tog_en | pwm_mode;
  assign interrupt_request = event_flag & int_en;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_capture_value;
    capture_hit |=> {capture_high, capture_low} == $past(count);
  endproperty
  a_capture_value: assert property (p_capture_value)
    else $error("capture registers do not hold the count at the edge");

  property p_edge_select;
    rise_en & ~fall_en & ev.fall & ~ev.rise |-> ~capture_hit;
  endproperty
  a_edge_select: assert property (p_edge_select)
    else $error("falling edge captured with only rising enable");

  property p_irq_cause;
    interrupt_request |-> event_flag && mode[`BIT_INT_EN];
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt request without flag and enable");

  property p_match_flag;
    match_hit |=> event_flag;
  endproperty
  a_match_flag: assert property (p_match_flag)
    else $error("match did not set the event flag");

  property p_flag_sticky;
    event_flag & ~flag_clear |=> event_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("event flag dropped without a software clear");

  property p_suspend;
    wr_low & ~wr_high |=> ~match_hit;
  endproperty
  a_suspend: assert property (p_suspend)
    else $error("match seen right after low compare write");

  property p_toggle;
    match_hit & tog_en & ~pwm_mode |=> module_pin_out != $past(module_pin_out);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("pin did not toggle on match");

  property p_no_toggle;
    ~tog_en & ~pwm_mode |=> $stable(module_pin_out);
  endproperty
  a_no_toggle: assert property (p_no_toggle)
    else $error("pin changed with toggle disabled");

  property p_pwm;
    pwm_mode |=> module_pin_out == ($past(count[7:0]) >= $past(capture_low));
  endproperty
  a_pwm: assert property (p_pwm)
    else $error("PWM pin level wrong");

  property p_wdt;
    watchdog_reset |-> IS_WATCHDOG && $past(wdt_en) && $past(match_hit);
  endproperty
  a_wdt: assert property (p_wdt)
    else $error("watchdog reset without enabled match");

  c_capture: cover property (capture_hit ##1 interrupt_request);
  c_toggle:  cover property (match_hit & tog_en);
  c_wdt:     cover property (watchdog_reset);
endmodule
`default_nettype wire

// *** dv/pin_model.sv ***
// Far-side model of the module pin: an outside source plus an edge counter
`timescale 1ns/1ps
`default_nettype none
module pin_model (
  // Clock
  input  wire logic clk,
  // Pin as the design sees it
  input  wire logic pin_out,
  input  wire logic pin_oe,
  input  wire logic drive_level,
  output logic      pin_in,
  output var int    toggle_cnt
);
  logic last_out = 1'b0;

  // Wire level: the design wins while it drives, else the outside source
  assign pin_in = pin_oe ? pin_out : drive_level;

  // Count every inversion made while the design drives the pin
  // The counter starts at zero as every int does, so one process owns it
  always @(posedge clk) begin
    if (pin_oe && (pin_out !== last_out)) toggle_cnt <= toggle_cnt + 1;
    last_out <= pin_out;
  end
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for the capture/compare module
`timescale 1ns/1ps
`default_nettype none
`include "cc_params.svh"
module testbench;
  logic        clk, reset_n, pin_lvl, pin_in, pin_out, pin_oe, irq, wd_reset, hit;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_data;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, rd_resp;
  logic [15:0] last, c;
  int          toggles, wd_cnt, error_cnt, checks_done, t0;
  logic [7:0]  fm [7] = '{8'h00, 8'h20, 8'h10, 8'h30, 8'h48, 8'h4C, 8'h42};
  int          fc [7] = '{0, 1, 1, 1, 2, 3, 4};
  logic [7:0]  cm [3] = '{8'h21, 8'h11, 8'h31};

  capture_compare_module #(.MODULE_INDEX(4), .ADDR_WIDTH(8)) u_dut (
    .clk(clk), .reset_n(reset_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .module_pin_in(pin_in), .module_pin_out(pin_out), .module_pin_oe(pin_oe),
    .interrupt_request(irq), .watchdog_reset(wd_reset)
  );

  pin_model u_pin (
    .clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .drive_level(pin_lvl),
    .pin_in(pin_in), .toggle_cnt(toggles)
  );

  // 40 MHz clock
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  // Count reset pulses; the pulse lasts one cycle so it is sampled every edge
  always @(posedge clk) begin
    if (!reset_n) wd_cnt <= 0;
    else if (wd_reset === 1'b1) wd_cnt <= wd_cnt + 1;
  end

  task automatic give_verdict();
    if (error_cnt == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic ga, gw;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ga = 1'b0;
    gw = 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (!ga && awready) begin
        ga = 1'b1;
        awvalid <= 1'b0;
      end
      if (!gw && wready) begin
        gw = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!bvalid && n < 200);
    if (n >= 200) error_cnt++;
    check({30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
  endtask

  // Read: rready held until rvalid is seen
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 200);
    if (n >= 200) error_cnt++;
    rd_data = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    check(rd_data & m, e);
  endtask

  // Let the count base run for k cycles; the stop write leaves the flag alone
  task automatic run(input int k);
    wr(`OFS_CONTROL, 32'h40, `RESP_OKAY);
    cyc(k);
    wr(`OFS_CONTROL, 32'h01, `RESP_OKAY);
  endtask

  // Hang guard, far beyond the several hundred cycles the sequence needs
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end

  initial begin
    reset_n = 1'b0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    {awvalid, wvalid, bready, arvalid, rready, pin_lvl} = '0;
    error_cnt = 0;
    checks_done = 0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    cyc(4);
    // Reset value, reserved bit and an unmapped place
    rdc(`OFS_MODE, 32'hFF, 32'h00);
    wr(`OFS_MODE, 32'h7F, `RESP_OKAY);
    rdc(`OFS_MODE, 32'hFF, 32'h7F);
    wr(8'h1C, 32'h5A, `RESP_SLVERR);
    rd(8'h1C);
    check(rd_data, 32'h0);
    check({30'h0, rd_resp}, {30'h0, `RESP_SLVERR});
    // Every documented mode decodes to its function and pin drive
    for (int i = 0; i < 7; i++) begin
      wr(`OFS_MODE, {24'h0, fm[i]}, `RESP_OKAY);
      rdc(`OFS_FUNCTION, 32'h7, fc[i]);
      check(pin_oe, fm[i][2] | fm[i][1]);
    end
    // Captures on each edge setting; stale values get overwritten
    last = 16'h0000;
    for (int i = 0; i < 3; i++) begin
      wr(`OFS_MODE, {24'h0, cm[i]}, `RESP_OKAY);
      for (int j = 0; j < 2; j++) begin
        wr(`OFS_CONTROL, 32'h00, `RESP_OKAY);
        c = 16'hA500 + 16'(i * 2 + j);
        wr(`OFS_COUNT, {16'h0, c}, `RESP_OKAY);
        @(posedge clk);
        pin_lvl <= (j == 0);
        cyc(8);
        hit = (j == 0) ? cm[i][5] : cm[i][4];
        if (hit) last = c;
        check(irq, hit);
        rdc(`OFS_CONTROL, 32'h01, {31'h0, hit});
        rdc(`OFS_CMP_LOW, 32'hFF, {24'h0, last[7:0]});
        rdc(`OFS_CMP_HIGH, 32'hFF, {24'h0, last[15:8]});
      end
    end
    // Flag without interrupt enable stays set until software clears it
    wr(`OFS_MODE, 32'h20, `RESP_OKAY);
    wr(`OFS_CONTROL, 32'h00, `RESP_OKAY);
    @(posedge clk);
    pin_lvl <= 1'b1;
    cyc(20);
    check(irq, 1'b0);
    rdc(`OFS_CONTROL, 32'h01, 32'h01);
    wr(`OFS_CONTROL, 32'h00, `RESP_OKAY);
    rdc(`OFS_CONTROL, 32'h01, 32'h00);
    // Software timer, compare written low byte first
    wr(`OFS_MODE, 32'h48, `RESP_OKAY);
    wr(`OFS_CMP_LOW, 32'h10, `RESP_OKAY);
    wr(`OFS_CMP_HIGH, 32'h00, `RESP_OKAY);
    wr(`OFS_COUNT, 32'h0, `RESP_OKAY);
    t0 = toggles;
    run(40);
    rdc(`OFS_CONTROL, 32'h01, 32'h01);
    check(wd_cnt, 0);
    // A lone low-byte write keeps the comparator quiet
    wr(`OFS_COUNT, 32'h0, `RESP_OKAY);
    wr(`OFS_CMP_LOW, 32'h20, `RESP_OKAY);
    run(40);
    rdc(`OFS_CONTROL, 32'h01, 32'h00);
    wr(`OFS_CMP_HIGH, 32'h00, `RESP_OKAY);
    wr(`OFS_COUNT, 32'h0, `RESP_OKAY);
    run(40);
    rdc(`OFS_CONTROL, 32'h01, 32'h01);
    check(toggles - t0, 0);
    // High-speed output, interrupt off, then the count base wrapping from FFF0 past zero
    wr(`OFS_MODE, 32'h4C, `RESP_OKAY);
    wr(`OFS_CMP_LOW, 32'h08, `RESP_OKAY);
    wr(`OFS_CMP_HIGH, 32'h00, `RESP_OKAY);
    wr(`OFS_COUNT, 32'h0, `RESP_OKAY);
    t0 = toggles;
    run(30);
    check(toggles - t0, 1);
    check(irq, 1'b0);
    wr(`OFS_COUNT, 32'hFFF0, `RESP_OKAY);
    run(40);
    check(toggles - t0, 2);
    // PWM level follows the low count byte against the low compare byte
    wr(`OFS_MODE, 32'h42, `RESP_OKAY);
    wr(`OFS_CMP_LOW, 32'h80, `RESP_OKAY);
    wr(`OFS_COUNT, 32'h7F, `RESP_OKAY);
    cyc(2);
    check(pin_out, 1'b0);
    wr(`OFS_COUNT, 32'h80, `RESP_OKAY);
    cyc(2);
    check(pin_out, 1'b1);
    // Watchdog compare on this module with the enable set, interrupt left off
    wr(`OFS_MODE, 32'h48, `RESP_OKAY);
    wr(`OFS_COUNTER_MODE, 32'h40, `RESP_OKAY);
    rdc(`OFS_FUNCTION, 32'h7, 32'h5);
    wr(`OFS_CMP_LOW, 32'h05, `RESP_OKAY);
    wr(`OFS_CMP_HIGH, 32'h00, `RESP_OKAY);
    wr(`OFS_COUNT, 32'h0, `RESP_OKAY);
    t0 = wd_cnt;
    run(20);
    check(wd_cnt - t0, 1);
    check(irq, 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
